// [pdlb_bound.sv]
`timescale 1ns/1ps
// Lower-boundary field of one descriptor, with fixed bits
module pdlb_bound #(
  parameter int W = 20,
  parameter logic [W-1:0] RST = '0,
  parameter logic [W-1:0] WMASK = '1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Byte write strobes and data
  input wire logic [2:0] wr,
  input wire logic [7:0] wdata,
  // Stored boundary
  output logic [W-1:0] bound
);

  typedef struct packed {
    logic [W-1:0] b;
  } pdlb_bnd_s;

  pdlb_bnd_s st_q;
  pdlb_bnd_s st_d;
  logic [W-1:0] nv;

  ////////////////////////////////////////////////////////////////////////////
  // Merge byte writes; fixed bits keep their reset value
  always_comb
  begin
    nv = st_q.b;
    if (wr[0])
    begin
      nv[W-1:16] = wdata[3:0];
    end
    if (wr[1])
    begin
      nv[15:8] = wdata;
    end
    if (wr[2])
    begin
      nv[7:0] = wdata;
    end
    st_d.b = (nv & WMASK) | (RST & ~WMASK);
  end

  // Register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q.b <= RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign bound = st_q.b;

endmodule : pdlb_bound

// [pdlb_chk.sv]
`timescale 1ns/1ps
// Protocol and register checks on the top module's ports
module pdlb_chk #(
  parameter logic [3:0] MASTER_IMPL = 4'hf,
  parameter logic [19:0] RANGE_LOW = 20'h0_0000,
  parameter logic [19:0] BOUND_WMASK = 20'hf_ffff
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Descriptor results
  input wire logic [7:0] desc_hit,
  input wire logic [7:0] desc_active
);
  logic setup;
  logic rd;
  logic [2:0] ptr_q;
  logic [2:0] wptr_q;
  logic act_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Phase decode
  assign setup = psel && !penable;
  assign rd = pready && !pwrite;
  // Mirror of the pointer and of the last select write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ptr_q <= 3'h0;
      wptr_q <= 3'h0;
      act_q <= 1'b0;
    end
    else if (setup && pwrite)
    begin
      if (paddr == 8'h24) ptr_q <= pwdata[2:0];
      if (paddr == 8'h18) wptr_q <= ptr_q;
      if (paddr == 8'h18) act_q <= |(pwdata[7:4] & MASTER_IMPL);
    end
  end
  ////////////////////////////////////////////////////////////////////
  rdy_next_a: assert property (setup |=> pready)
    else $error("no ready after setup");
  err_far_a: assert property (pready && paddr > 8'h2c |-> pslverr)
    else $error("unmapped without error");
  sel_impl_a: assert property (
    rd && paddr == 8'h18 |-> (prdata[7:4] & ~MASTER_IMPL) == 4'h0)
    else $error("absent master bit read");
  upper_zero_a: assert property (
    rd && !pslverr |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  fixed_bit_a: assert property (rd && paddr == 8'h20 |->
    ((prdata[7:0] ^ RANGE_LOW[7:0]) & ~BOUND_WMASK[7:0]) == 8'h00)
    else $error("fixed bound bit changed");
  act_rst_a: assert property (
    $rose(presetn) |=> desc_active == {7'h00, |MASTER_IMPL})
    else $error("active after reset");
  act_sel_a: assert property (
    setup && pwrite && paddr == 8'h18 |-> ##2 desc_active[wptr_q] == act_q)
    else $error("active not from select");
  hit_act_a: assert property ((desc_hit & ~desc_active) == 8'h00)
    else $error("hit on disabled descriptor");
endmodule : pdlb_chk

bind pdlb_top pdlb_chk #(
  .MASTER_IMPL(MASTER_IMPL),
  .RANGE_LOW(RANGE_LOW),
  .BOUND_WMASK(BOUND_WMASK)
) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .desc_hit(desc_hit),
  .desc_active(desc_active)
);

// [pdlb_pkg.sv]
package pdlb_pkg;

  // Register word indices, byte address is index << 2 (each register one aligned word)
  localparam logic [7:0] ADDR_SEL_HI = 8'h06 << 2;
  localparam logic [7:0] IDX_SEL_HI = 8'h06;
  localparam logic [7:0] IDX_MID = 8'h07;
  localparam logic [7:0] IDX_LOW = 8'h08;
  localparam logic [7:0] IDX_CFG = 8'h09;
  localparam logic [7:0] IDX_STAT = 8'h0a;
  localparam logic [7:0] IDX_CHECK = 8'h0b;
  localparam logic [7:0] IDX_RESULT = 8'h0c;

  // Field positions in the first descriptor byte
  localparam int SUP_BIT = 7;
  localparam int USR_BIT = 6;
  localparam int COP_BIT = 5;
  localparam int FTH_BIT = 4;

  // Widths
  localparam int ADDR_W = 23;
  localparam int BOUND_W = 20;
  localparam int NDESC = 8;
  localparam int DSEL_W = 3;

  // Reset values
  localparam logic [3:0] SEL_RST_D0 = 4'hf;
  localparam logic [3:0] SEL_RST_DN = 4'h0;
  localparam logic [7:0] SEL_HI_RST = 8'hf0;

endpackage : pdlb_pkg

// [pdlb_select.sv]
`timescale 1ns/1ps
// Master-select nibble of one descriptor, with implemented-master masking
module pdlb_select #(
  parameter logic [3:0] IMPL = 4'hf,
  parameter logic [3:0] RST = 4'h0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write port
  input wire logic wr,
  input wire logic [3:0] wdata,
  // Stored nibble
  output logic [3:0] sel
);

  typedef struct packed {
    logic [3:0] sel;
  } pdlb_sel_s;

  pdlb_sel_s st_q;
  pdlb_sel_s st_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: absent masters never set
  always_comb
  begin
    st_d = st_q;
    if (wr)
    begin
      st_d.sel = wdata & IMPL;
    end
  end

  // Register, reset masked by presence
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q.sel <= RST & IMPL;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign sel = st_q.sel;

endmodule : pdlb_select

// [pdlb_top.sv]
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
// Operation
// - Select bit 7 makes the descriptor apply to the supervisor CPU.
// - Select bit 6 applies it to the user CPU, settable only with user state.
// - Select bit 5 applies it to the coprocessor, settable only if present.
// - Select bit 4 applies it to the fourth master, if configured.
// - Several select bits may be set so one descriptor serves many masters.
// - A descriptor with no select bit set is disabled.
// - Select bits of absent masters ignore writes and read as zero.
// - First byte bits 3..0 hold boundary address bits 22..19.
// - Second byte holds boundary address bits 18..11.
// - Third byte holds boundary address bits 10..3.
// - Reset loads every boundary with the lowest covered address.
// - Reset sets masters 0..2 in descriptor 0 only, each when it is present.
// - Reset sets master 3 in descriptor 0 only, when it is present.
// - Boundary bits fixed by granularity and range ignore writes.
module pdlb_top #(
  parameter logic [3:0] MASTER_IMPL = 4'hf,
  parameter logic [19:0] RANGE_LOW = 20'h0_0000,
  parameter logic [19:0] BOUND_WMASK = 20'hf_ffff
) (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Access check request
  input wire logic [22:0] acc_addr,
  input wire logic [1:0] acc_master,
  // Per-descriptor results
  output logic [7:0] desc_hit,
  output logic [7:0] desc_active
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [2:0] dsel;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [7:0] hit;
    logic [7:0] active;
  } pdlb_top_s;

  pdlb_top_s st_q;
  pdlb_top_s st_d;

  logic [3:0] sel [pdlb_pkg::NDESC];
  logic [19:0] bnd [pdlb_pkg::NDESC];
  logic [2:0] bnd_wr;
  logic setup;
  logic [5:0] idx;
  logic map_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode, taken in the setup cycle
  assign setup = psel && !penable;
  assign idx = paddr[7:2];
  always_comb
  begin
    map_ok = (paddr[1:0] == 2'b00) &&
      ({2'b00, idx} >= pdlb_pkg::IDX_SEL_HI) &&
      ({2'b00, idx} <= pdlb_pkg::IDX_LOW + 8'h01);
  end

  // Write strobes into the currently selected descriptor
  always_comb
  begin
    bnd_wr = 3'b000;
    if (setup && pwrite)
    begin
      if ({2'b00, idx} == pdlb_pkg::IDX_SEL_HI)
      begin
        bnd_wr[0] = 1'b1;
      end
      if ({2'b00, idx} == pdlb_pkg::IDX_MID)
      begin
        bnd_wr[1] = 1'b1;
      end
      if ({2'b00, idx} == pdlb_pkg::IDX_LOW)
      begin
        bnd_wr[2] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor storage
  genvar g;
  generate
    for (g = 0; g < pdlb_pkg::NDESC; g++)
    begin : g_desc
      logic mine;
      assign mine = (st_q.dsel == 3'(g));
      pdlb_select #(
        .IMPL(MASTER_IMPL),
        .RST((g == 0) ? pdlb_pkg::SEL_RST_D0 : pdlb_pkg::SEL_RST_DN)
      ) u_sel (
        .pclk(pclk),
        .presetn(presetn),
        .wr(mine && bnd_wr[0]),
        .wdata(pwdata[7:4]),
        .sel(sel[g])
      );
      pdlb_bound #(
        .W(pdlb_pkg::BOUND_W),
        .RST(RANGE_LOW),
        .WMASK(BOUND_WMASK)
      ) u_bnd (
        .pclk(pclk),
        .presetn(presetn),
        .wr(mine ? bnd_wr : 3'b000),
        .wdata(pwdata[7:0]),
        .bound(bnd[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Bus response, descriptor pointer and access check
  always_comb
  begin
    logic [3:0] s;
    logic [22:0] lo;
    s = 4'h0;
    lo = '0;
    st_d = st_q;
    st_d.ready = setup;
    st_d.err = setup && !map_ok;
    if (setup && !pwrite)
    begin
      st_d.rdata = 32'h0000_0000;
      case ({2'b00, idx})
        pdlb_pkg::IDX_SEL_HI:
        begin
          st_d.rdata[7:0] = {sel[st_q.dsel], bnd[st_q.dsel][19:16]};
        end
        pdlb_pkg::IDX_MID:
        begin
          st_d.rdata[7:0] = bnd[st_q.dsel][15:8];
        end
        pdlb_pkg::IDX_LOW:
        begin
          st_d.rdata[7:0] = bnd[st_q.dsel][7:0];
        end
        pdlb_pkg::IDX_CFG:
        begin
          st_d.rdata[2:0] = st_q.dsel;
        end
        default:
        begin
          st_d.rdata = 32'h0000_0000;
        end
      endcase
    end
    else if (setup)
    begin
      st_d.rdata = 32'h0000_0000;
      if ({2'b00, idx} == pdlb_pkg::IDX_CFG)
      begin
        st_d.dsel = pwdata[2:0];
      end
    end
    for (int i = 0; i < pdlb_pkg::NDESC; i++)
    begin
      s = sel[i];
      lo = {bnd[i], 3'b000};
      st_d.active[i] = |s;
      // One bit per master; any set bit serves its master
      st_d.hit[i] = s[3 - acc_master] && (acc_addr >= lo);
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs from flip-flops
  assign prdata = st_q.rdata;
  assign pready = st_q.ready;
  assign pslverr = st_q.err;
  assign desc_hit = st_q.hit;
  assign desc_active = st_q.active;

endmodule : pdlb_top

// [tb_pdlb_top.sv]
`timescale 1ns/1ps
// Register and match tests through APB
module tb_pdlb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [22:0] acc_addr = 23'h00_0000;
  logic [1:0] acc_master = 2'h0;
  logic [7:0] desc_hit;
  logic [7:0] desc_active;
  logic [31:0] rdat;
  logic rerr;
  int err_total = 0;
  int samples_checked = 0;
  localparam logic [22:0] BASE = 23'h2a_d7f0;
  localparam logic [3:0] HITS = 4'hb;
  // Coprocessor absent, one fixed bound bit, nonzero range start
  pdlb_top #(
    .MASTER_IMPL(4'hd),
    .RANGE_LOW(20'h0_0010),
    .BOUND_WMASK(20'hf_fffe)
  ) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .acc_addr(acc_addr),
    .acc_master(acc_master), .desc_hit(desc_hit),
    .desc_active(desc_active)
  );
  // 25 MHz clock
  always #20 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk
  // One APB transfer, then one idle cycle
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task rchk(input logic [7:0] a, input logic [31:0] e, input logic x);
    xfer(1'b0, a, 32'h0000_0000);
    chk({31'h0, rerr}, {31'h0, x});
    chk(rdat, e);
  endtask : rchk
  task probe(input int d, input logic [1:0] m, input logic [22:0] a,
    input logic e);
    acc_master <= m;
    acc_addr <= a;
    repeat (2) @(posedge pclk);
    chk({31'h0, desc_hit[d]}, {31'h0, e});
  endtask : probe
  task finish_test;
    $display("Checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(8'h18, 32'h0000_00d0, 1'b0);
    rchk(8'h1c, 32'h0000_0000, 1'b0);
    rchk(8'h20, 32'h0000_0010, 1'b0);
    probe(0, 2'h0, 23'h00_0080, 1'b1);
    probe(0, 2'h0, 23'h00_007f, 1'b0);
    xfer(1'b1, 8'h24, 32'h0000_0003);
    rchk(8'h24, 32'h0000_0003, 1'b0);
    rchk(8'h18, 32'h0000_0000, 1'b0);
    xfer(1'b1, 8'h18, 32'hffff_fff5);
    rchk(8'h18, 32'h0000_00d5, 1'b0);
    xfer(1'b1, 8'h1c, 32'hffff_ff5a);
    rchk(8'h1c, 32'h0000_005a, 1'b0);
    xfer(1'b1, 8'h20, 32'h0000_00ff);
    rchk(8'h20, 32'h0000_00fe, 1'b0);
    for (int m = 0; m < 4; m++)
    begin
      probe(3, m[1:0], BASE, HITS[m]);
      probe(3, m[1:0], BASE - 23'h1, 1'b0);
    end
    chk(32'(desc_active), 32'h0000_0009);
    xfer(1'b1, 8'h18, 32'h0000_0005);
    chk(32'(desc_active), 32'h0000_0001);
    probe(3, 2'h0, BASE, 1'b0);
    rchk(8'h40, 32'h0000_0000, 1'b1);
    finish_test();
  end
  // Watchdog
  initial
  begin
    repeat (2000) @(posedge pclk);
    err_total++;
    finish_test();
  end
endmodule : tb_pdlb_top
